/* rtl/video_pkg.sv */
package video_pkg;

  // Register byte offsets on the APB port.
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] BASE_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] PAL_OFF = 8'h40;
  localparam logic [1:0] PAL_SEL_HI = 2'h1;

  // Resolution field codes held in the control register.
  localparam logic [1:0] RES_LOW = 2'h0;
  localparam logic [1:0] RES_MED = 2'h1;
  localparam logic [1:0] RES_HIGH = 2'h2;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Field layout of a palette entry: red, green, blue, three bits each.
  localparam int PAL_ENTRIES = 16;
  localparam int COMP_W = 3;
  localparam int PAL_W = 3 * COMP_W;
  localparam int RED_LSB = 6;
  localparam int GREEN_LSB = 3;
  localparam int BLUE_LSB = 0;

  // Display memory geometry, in words of 16 bits.
  localparam int WORD_W = 16;
  localparam int MAX_PLANES = 4;
  localparam int OFFS_W = 14;
  localparam int BASE_W = 16;
  localparam int BASE_SHIFT = 7;
  localparam int WADDR_W = BASE_W + BASE_SHIFT;

  // Raster timing, counted in pixels and lines.
  localparam int HV_W = 10;
  localparam int GROUP_PIX = 16;
  localparam int PIX_DIV_DEF = 2;
  localparam int H_ACT_DEF = 320;
  localparam int H_TOTAL_DEF = 400;
  localparam int HS_START_DEF = 352;
  localparam int HS_WIDTH_DEF = 24;
  localparam int V_ACT_DEF = 200;
  localparam int V_TOTAL_DEF = 262;
  localparam int VS_START_DEF = 230;
  localparam int VS_WIDTH_DEF = 3;

  // Number of interleaved planes for a resolution; a monochrome monitor forces one.
  function automatic logic [2:0] plane_count(input logic [1:0] res, input logic mono);
    if (mono || res == RES_HIGH) begin
      plane_count = 3'h1;
    end else if (res == RES_MED) begin
      plane_count = 3'h2;
    end else begin
      plane_count = 3'h4;
    end
  endfunction

endpackage

/* rtl/video_shifter.sv */
`timescale 1ns/1ns
module video_shifter (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Word load from memory
  input logic load,
  input logic [1:0] slot,
  input logic [video_pkg::WORD_W-1:0] data,
  // Pixel timing
  input logic xfer,
  input logic shift,
  input logic [1:0] res,
  input logic mono,
  // Palette index of the current pixel
  output logic [3:0] pix_index
);
  import video_pkg::*;

  logic [WORD_W-1:0] hold_reg [MAX_PLANES];
  logic [WORD_W-1:0] sh_reg [MAX_PLANES];
  logic [2:0] planes;

  assign planes = plane_count(res, mono);

  // Words for the next group wait here while the current group is shifted out.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MAX_PLANES; i++) begin
        hold_reg[i] <= '0;
      end
    end else if (load) begin
      hold_reg[slot] <= data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MAX_PLANES; i++) begin
        sh_reg[i] <= '0;
      end
    end else if (xfer) begin
      for (int i = 0; i < MAX_PLANES; i++) begin
        sh_reg[i] <= hold_reg[i];
      end
    end else if (shift) begin
      for (int i = 0; i < MAX_PLANES; i++) begin
        sh_reg[i] <= {1'b0, sh_reg[i][WORD_W-1:1]};
      end
    end
  end

  // Unused planes are masked so that fewer planes reach only the low palette entries.
  always_comb begin
    pix_index = {sh_reg[3][0], sh_reg[2][0], sh_reg[1][0], sh_reg[0][0]};
    if (planes == 3'h1) begin
      pix_index = {3'h0, sh_reg[0][0]};
    end else if (planes == 3'h2) begin
      pix_index = {2'h0, sh_reg[1][0], sh_reg[0][0]};
    end
  end

  property p_shift_order;
    @(posedge pclk) disable iff (!presetn)
      shift && !xfer |=> sh_reg[0] == {1'b0, $past(sh_reg[0][WORD_W-1:1])};
  endproperty
  a_shift_order: assert property (p_shift_order) else $error("plane 0 did not shift");

  property p_group_load;
    @(posedge pclk) disable iff (!presetn)
      xfer |=> sh_reg[3] == $past(hold_reg[3]) && sh_reg[0] == $past(hold_reg[0]);
  endproperty
  a_group_load: assert property (p_group_load) else $error("group not loaded");

endmodule

/* rtl/planar_video_fetch_shifter.sv */
`timescale 1ns/1ns
// What this block does
// - Screen memory holds one, two or four planes interleaved word by word.
// - Screen spans 32 kilobytes starting on a 256-byte boundary.
// - First word fetched from the base is the top-left pixel group.
// - Memory words of 16 bits are loaded and serialised into pixels.
// - Monochrome: each bit is one pixel, set is on, clear is off.
// - Low resolution loads four words, one per plane, per 16 pixels.
// - Same bit of every plane forms a 4-bit palette index.
// - Pixels leave in rising bit order, bit 0 first.
// - Vertical sync in vertical blanking reloads the address counter from base.
// - Words are fetched and loaded only while the active-line signal is high.
// - Video output is forced off while blanking.
// - Horizontal and vertical sync drive the monitor in step with pixels.
// - A load strobe pulse latches each fetched word into the shifter.
// - Palette select is high only during palette-changing accesses.
// - Low monochrome detect means a monochrome monitor.
// - Sixteen palette entries, each three bits of red, green, blue.
// - Monochrome bypasses the palette; entry 0 bit 0 inverts the output.
module planar_video_fetch_shifter #(
  parameter int PIX_DIV = video_pkg::PIX_DIV_DEF,
  parameter int H_ACT = video_pkg::H_ACT_DEF,
  parameter int H_TOTAL = video_pkg::H_TOTAL_DEF,
  parameter int HS_START = video_pkg::HS_START_DEF,
  parameter int HS_WIDTH = video_pkg::HS_WIDTH_DEF,
  parameter int V_ACT = video_pkg::V_ACT_DEF,
  parameter int V_TOTAL = video_pkg::V_TOTAL_DEF,
  parameter int VS_START = video_pkg::VS_START_DEF,
  parameter int VS_WIDTH = video_pkg::VS_WIDTH_DEF
) (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Display memory
  output logic [video_pkg::WADDR_W-1:0] mem_addr,
  output logic mem_rd,
  input logic [video_pkg::WORD_W-1:0] mem_rdata,
  output logic shift_load_strobe,
  output logic palette_select,
  // Raster timing
  output logic active_line,
  output logic blank,
  output logic hsync_n,
  output logic vsync_n,
  // Monitor
  input logic mono_detect,
  output logic [video_pkg::COMP_W-1:0] red,
  output logic [video_pkg::COMP_W-1:0] green,
  output logic [video_pkg::COMP_W-1:0] blue,
  output logic mono_out
);
  import video_pkg::*;

  localparam logic [HV_W-1:0] H_ACT_C = HV_W'(H_ACT);
  localparam logic [HV_W-1:0] H_DISP_END = HV_W'(H_ACT + GROUP_PIX);
  localparam logic [HV_W-1:0] H_LAST = HV_W'(H_TOTAL - 1);
  localparam logic [HV_W-1:0] HS_BEG = HV_W'(HS_START);
  localparam logic [HV_W-1:0] HS_END = HV_W'(HS_START + HS_WIDTH);
  localparam logic [HV_W-1:0] V_ACT_C = HV_W'(V_ACT);
  localparam logic [HV_W-1:0] V_LAST = HV_W'(V_TOTAL - 1);
  localparam logic [HV_W-1:0] VS_BEG = HV_W'(VS_START);
  localparam logic [HV_W-1:0] VS_END = HV_W'(VS_START + VS_WIDTH);
  localparam logic [HV_W-1:0] GROUP_C = HV_W'(GROUP_PIX);
  localparam logic [3:0] DIV_LAST = 4'(PIX_DIV - 1);

  logic [1:0] res_reg;
  logic [BASE_W-1:0] base_reg;
  logic [PAL_W-1:0] pal_mem [PAL_ENTRIES];
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic palette_select_reg;
  logic [3:0] div_reg;
  logic [HV_W-1:0] h_reg;
  logic [HV_W-1:0] v_reg;
  logic active_line_reg;
  logic blank_reg;
  logic hsync_n_reg;
  logic vsync_n_reg;
  logic [OFFS_W-1:0] offset_reg;
  logic [BASE_W-1:0] cur_base_reg;
  logic [WADDR_W-1:0] mem_addr_reg;
  logic mem_rd_reg;
  logic [1:0] slot_reg;
  logic shift_load_strobe_reg;
  logic [1:0] load_slot_reg;
  logic [COMP_W-1:0] red_reg;
  logic [COMP_W-1:0] green_reg;
  logic [COMP_W-1:0] blue_reg;
  logic mono_out_reg;

  logic setup;
  logic access;
  logic pal_hit;
  logic known;
  logic [31:0] rd_data;
  logic mono_mode;
  logic pix_en;
  logic de_now;
  logic disp_now;
  logic hs_now;
  logic vs_now;
  logic vblank_now;
  logic [3:0] px;
  logic [2:0] planes;
  logic fetch_go;
  logic reload;
  logic xfer;
  logic [3:0] pix_index;
  logic [PAL_W-1:0] colour;

  assign mono_mode = !mono_detect;

  // APB decode. Every access is answered in its first access cycle.
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pal_hit = paddr[7:6] == PAL_SEL_HI && paddr[1:0] == 2'h0;
  assign known = paddr == CTRL_OFF || paddr == BASE_OFF || paddr == STAT_OFF || pal_hit;

  always_comb begin
    rd_data = 32'h0;
    if (pal_hit) begin
      rd_data = {23'h0, pal_mem[paddr[5:2]]};
    end else if (paddr == CTRL_OFF) begin
      rd_data = {30'h0, res_reg};
    end else if (paddr == BASE_OFF) begin
      rd_data = {8'h0, base_reg, 8'h0};
    end else if (paddr == STAT_OFF) begin
      rd_data = {14'h0, vblank_now, mono_mode, 6'h0, v_reg};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      pslverr_reg <= setup && !known;
      if (setup && !pwrite) begin
        prdata_reg <= rd_data;
      end
    end
  end

  // The base ignores the low byte so the screen always starts on a page.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_reg <= CTRL_RESET;
      base_reg <= '0;
    end else if (access && pwrite) begin
      if (paddr == CTRL_OFF) begin
        res_reg <= pwdata[1:0];
      end
      if (paddr == BASE_OFF) begin
        base_reg <= pwdata[23:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PAL_ENTRIES; i++) begin
        pal_mem[i] <= '0;
      end
    end else if (access && pwrite && pal_hit) begin
      pal_mem[paddr[5:2]] <= pwdata[PAL_W-1:0];
    end
  end

  // Registered from the setup cycle, so it is high exactly in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      palette_select_reg <= 1'b0;
    end else begin
      palette_select_reg <= setup && pwrite && pal_hit;
    end
  end

  // Pixel rate enable and raster counters.
  assign pix_en = div_reg == DIV_LAST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= pix_en ? 4'h0 : div_reg + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_reg <= '0;
      v_reg <= '0;
    end else if (pix_en) begin
      if (h_reg == H_LAST) begin
        h_reg <= '0;
        v_reg <= (v_reg == V_LAST) ? '0 : v_reg + 1'b1;
      end else begin
        h_reg <= h_reg + 1'b1;
      end
    end
  end

  // Fetching runs one pixel group ahead of the visible pixels.
  assign de_now = h_reg < H_ACT_C && v_reg < V_ACT_C;
  assign disp_now = h_reg >= GROUP_C && h_reg < H_DISP_END && v_reg < V_ACT_C;
  assign hs_now = h_reg >= HS_BEG && h_reg < HS_END;
  assign vs_now = v_reg >= VS_BEG && v_reg < VS_END;
  assign vblank_now = v_reg >= V_ACT_C;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_line_reg <= 1'b0;
      blank_reg <= 1'b1;
      hsync_n_reg <= 1'b1;
      vsync_n_reg <= 1'b1;
    end else begin
      active_line_reg <= de_now;
      blank_reg <= !disp_now;
      hsync_n_reg <= !hs_now;
      vsync_n_reg <= !vs_now;
    end
  end

  // Fetch control.
  assign px = h_reg[3:0];
  assign planes = plane_count(res_reg, mono_mode);
  assign fetch_go = pix_en && de_now && px < {1'b0, planes};
  assign reload = vs_now && vblank_now;
  assign xfer = pix_en && de_now && px == 4'hf;

  // Offset is kept within the 32 kilobyte screen, so it wraps there.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_reg <= '0;
      cur_base_reg <= '0;
    end else if (reload) begin
      offset_reg <= '0;
      cur_base_reg <= base_reg;
    end else if (fetch_go) begin
      offset_reg <= offset_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr_reg <= '0;
      mem_rd_reg <= 1'b0;
      slot_reg <= 2'h0;
    end else begin
      mem_rd_reg <= fetch_go;
      if (fetch_go) begin
        mem_addr_reg <= {cur_base_reg, BASE_SHIFT'(0)} + WADDR_W'(offset_reg);
        slot_reg <= px[1:0];
      end
    end
  end

  // Memory returns the word one cycle after the read; the strobe marks it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_load_strobe_reg <= 1'b0;
      load_slot_reg <= 2'h0;
    end else begin
      shift_load_strobe_reg <= mem_rd_reg;
      load_slot_reg <= slot_reg;
    end
  end

  video_shifter u_shifter (
    .pclk(pclk),
    .presetn(presetn),
    .load(shift_load_strobe_reg),
    .slot(load_slot_reg),
    .data(mem_rdata),
    .xfer(xfer),
    .shift(pix_en),
    .res(res_reg),
    .mono(mono_mode),
    .pix_index(pix_index)
  );

  // Colour output.
  assign colour = pal_mem[pix_index];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      red_reg <= '0;
      green_reg <= '0;
      blue_reg <= '0;
      mono_out_reg <= 1'b0;
    end else if (!disp_now) begin
      red_reg <= '0;
      green_reg <= '0;
      blue_reg <= '0;
      mono_out_reg <= 1'b0;
    end else if (mono_mode) begin
      red_reg <= '0;
      green_reg <= '0;
      blue_reg <= '0;
      mono_out_reg <= pix_index[0] ^ pal_mem[0][0];
    end else begin
      red_reg <= colour[RED_LSB +: COMP_W];
      green_reg <= colour[GREEN_LSB +: COMP_W];
      blue_reg <= colour[BLUE_LSB +: COMP_W];
      mono_out_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_rd = mem_rd_reg;
  assign shift_load_strobe = shift_load_strobe_reg;
  assign palette_select = palette_select_reg;
  assign active_line = active_line_reg;
  assign blank = blank_reg;
  assign hsync_n = hsync_n_reg;
  assign vsync_n = vsync_n_reg;
  assign red = red_reg;
  assign green = green_reg;
  assign blue = blue_reg;
  assign mono_out = mono_out_reg;

  property p_strobe_follows_read;
    @(posedge pclk) disable iff (!presetn)
      mem_rd_reg |=> shift_load_strobe_reg ##1 !shift_load_strobe_reg;
  endproperty
  a_strobe_follows_read: assert property (p_strobe_follows_read) else $error("no load strobe");

  property p_fetch_in_line;
    @(posedge pclk) disable iff (!presetn)
      mem_rd_reg |-> active_line_reg;
  endproperty
  a_fetch_in_line: assert property (p_fetch_in_line) else $error("fetch outside line");

  property p_addr_step;
    @(posedge pclk) disable iff (!presetn)
      fetch_go && !reload |=> offset_reg == $past(offset_reg) + 1'b1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address did not step");

  property p_addr_hold;
    @(posedge pclk) disable iff (!presetn)
      !de_now && !reload |=> $stable(offset_reg);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved off line");

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
      reload |=> offset_reg == '0 && cur_base_reg == $past(base_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload in vsync");

  property p_blank_dark;
    @(posedge pclk) disable iff (!presetn)
      blank_reg |-> red_reg == '0 && green_reg == '0 && blue_reg == '0 && !mono_out_reg;
  endproperty
  a_blank_dark: assert property (p_blank_dark) else $error("video during blank");

  property p_palette_select;
    @(posedge pclk) disable iff (!presetn)
      palette_select_reg |-> $past(setup && pwrite && pal_hit) && access;
  endproperty
  a_palette_select: assert property (p_palette_select) else $error("stray palette select");

  property p_mono_bypass;
    @(posedge pclk) disable iff (!presetn)
      !mono_detect |=> red_reg == '0 && green_reg == '0 && blue_reg == '0;
  endproperty
  a_mono_bypass: assert property (p_mono_bypass) else $error("colour in mono mode");

  property p_first_word;
    @(posedge pclk) disable iff (!presetn)
      fetch_go && offset_reg == '0 |=> mem_addr_reg == {cur_base_reg, BASE_SHIFT'(0)};
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word not at base");

endmodule

/* tb/mem_model.sv */
`timescale 1ns/1ns
package tb_mem_pkg;

  // Contents of display memory, different in every word of any 256-word span, so in every plane.
  function automatic logic [15:0] mem_word(input logic [22:0] a);
    mem_word = {a[7:0] ^ 8'ha5, a[7:0] * 8'h1d + 8'h3c};
  endfunction

endpackage

module mem_model (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Fetch request
  input logic mem_rd,
  input logic [video_pkg::WADDR_W-1:0] mem_addr,
  // Read data
  output logic [video_pkg::WORD_W-1:0] mem_rdata
);
  import video_pkg::*;
  import tb_mem_pkg::*;

  // Data is valid only in the cycle after a read; otherwise the bus toggles, so a sample
  // one cycle late sees the inverted word, while one two cycles late sees the right word again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rdata <= 16'h0;
    end else if (mem_rd) begin
      mem_rdata <= mem_word(mem_addr);
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import video_pkg::*;
  import tb_mem_pkg::*;

  // Short raster so that a whole frame takes about a thousand clocks.
  localparam int PD = 2;
  localparam int HA = 32;
  localparam int HT = 64;
  localparam int HSW = 4;
  localparam int VA = 4;
  localparam int VT = 8;
  localparam int VSW = 1;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mono_detect;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [WADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_rdata;
  logic mem_rd, shift_load_strobe, palette_select, active_line, blank, hsync_n, vsync_n;
  logic [COMP_W-1:0] red, green, blue;
  logic mono_out, strobe_exp;
  logic [PAL_W-1:0] pal [PAL_ENTRIES];
  int fails, n_checks, cyc;

  planar_video_fetch_shifter #(.PIX_DIV(PD), .H_ACT(HA), .H_TOTAL(HT), .HS_START(50),
    .HS_WIDTH(HSW), .V_ACT(VA), .V_TOTAL(VT), .VS_START(5), .VS_WIDTH(VSW)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .shift_load_strobe(shift_load_strobe), .palette_select(palette_select),
    .active_line(active_line), .blank(blank), .hsync_n(hsync_n), .vsync_n(vsync_n),
    .mono_detect(mono_detect), .red(red), .green(green), .blue(blue), .mono_out(mono_out));

  mem_model memory (.pclk(pclk), .presetn(presetn), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e, output logic ps);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // A slave that never answers is caught by the run's own timeout.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    ps = palette_select;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e, ps;
    apb(1'b1, a, d, q, e, ps);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    logic e, ps;
    apb(1'b0, a, 32'h0, q, e, ps);
    chk(q === exp && e === 1'b0 && ps === 1'b0, msg);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic e, ps;
    rd(CTRL_OFF, 32'h0, "control reset value");
    rd(BASE_OFF, 32'h0, "base reset value");
    for (int i = 0; i < PAL_ENTRIES; i++) begin
      rd(PAL_OFF + 8'(4 * i), 32'h0, "palette reset value");
    end
    apb(1'b1, 8'h0c, 32'h1, q, e, ps);
    chk(e === 1'b1 && ps === 1'b0, "unmapped write");
    apb(1'b1, PAL_OFF + 8'h1, 32'h1, q, e, ps);
    chk(e === 1'b1 && ps === 1'b0, "misaligned palette write");
    wr(BASE_OFF, 32'h001234ff);
    rd(BASE_OFF, 32'h00123400, "base alignment");
    wr(CTRL_OFF, 32'hfffffffd);
    rd(CTRL_OFF, 32'h1, "control field width");
    for (int i = 0; i < PAL_ENTRIES; i++) begin
      pal[i] = PAL_W'(i * 37 + 3);
      apb(1'b1, PAL_OFF + 8'(4 * i), 32'hfffffe00 | 32'(pal[i]), q, e, ps);
      chk(ps === 1'b1 && e === 1'b0, "palette select on write");
      rd(PAL_OFF + 8'(4 * i), 32'(pal[i]), "palette readback");
    end
  endtask

  function automatic logic sync_sig(input logic vert);
    return vert ? vsync_n : hsync_n;
  endfunction

  task automatic measure(input logic vert, output int lo, output int hi);
    int n;
    n = 0;
    while (sync_sig(vert) !== 1'b1 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    while (sync_sig(vert) !== 1'b0 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    lo = 0;
    while (sync_sig(vert) === 1'b0 && lo < 3000) begin
      @(negedge pclk);
      lo++;
    end
    hi = 0;
    while (sync_sig(vert) === 1'b1 && hi < 3000) begin
      @(negedge pclk);
      hi++;
    end
  endtask

  task automatic t_sync;
    int lo, hi;
    measure(1'b0, lo, hi);
    chk(lo == HSW * PD && lo + hi == HT * PD, "horizontal sync timing");
    measure(1'b1, lo, hi);
    chk(lo == VSW * HT * PD && lo + hi == VT * HT * PD, "vertical sync timing");
  endtask

  // One frame in a mode: every fetch address and count, then the first line's pixels.
  task automatic t_mode(input logic [1:0] res, input logic mono, input logic [23:0] base);
    logic [WADDR_W-1:0] bw;
    logic [31:0] q;
    logic e, ps;
    logic [3:0] idx;
    logic [WORD_W-1:0] w;
    int planes, nf, np;
    bw = {base[23:8], 7'h0};
    planes = mono ? 1 : (res == RES_MED ? 2 : (res == RES_HIGH ? 1 : 4));
    wr(CTRL_OFF, {30'h0, res});
    mono_detect <= ~mono;
    wr(BASE_OFF, {8'h0, base});
    apb(1'b0, STAT_OFF, 32'h0, q, e, ps);
    chk(q[16] === mono, "monitor type status");
    np = 0;
    while (vsync_n !== 1'b0 && np < 3000) begin
      @(negedge pclk);
      np++;
    end
    while (vsync_n !== 1'b1 && np < 3000) begin
      @(negedge pclk);
      np++;
    end
    nf = 0;
    np = 0;
    fork
      while (vsync_n !== 1'b0 && np < 3000) begin
        @(negedge pclk);
        np++;
        if (mem_rd === 1'b1) begin
          chk(mem_addr === WADDR_W'(bw + nf), "fetch address");
          chk(active_line === 1'b1, "fetch outside active line");
          nf++;
        end
      end
      begin
        while (blank !== 1'b0 && np < 3000) begin
          chk({red, green, blue, mono_out} === 10'h0, "output while blank");
          @(negedge pclk);
        end
        for (int p = 0; p < HA; p++) begin
          idx = 4'h0;
          for (int k = 0; k < planes; k++) begin
            w = mem_word(WADDR_W'(bw + (p / 16) * planes + k));
            idx[k] = w[p % 16];
          end
          if (mono) begin
            chk(mono_out === (idx[0] ^ pal[0][0]) && {red, green, blue} === 9'h0,
                "mono pixel");
          end else begin
            chk({red, green, blue} === pal[idx] && mono_out === 1'b0,
                "colour pixel");
          end
          repeat (PD) @(negedge pclk);
        end
      end
    join
    chk(nf == planes * (HA / 16) * VA, "fetches per frame");
  endtask

  // Sampled on the falling edge, where the strobe has settled.
  always @(negedge pclk) begin
    if (presetn === 1'b1) begin
      chk(shift_load_strobe === strobe_exp, "load strobe timing");
    end
    strobe_exp <= mem_rd;
    cyc++;
    if (cyc == 40000) begin
      fails++;
      $display("wrong value at %0t: run timed out", $time);
      complete_run;
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    mono_detect = 1'b1;
    strobe_exp = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_sync;
    t_mode(RES_LOW, 1'b0, 24'h012300);
    t_mode(RES_MED, 1'b0, 24'h045600);
    t_mode(RES_HIGH, 1'b0, 24'h07ff00);
    t_mode(RES_MED, 1'b1, 24'h0a0100);
    complete_run;
  end
endmodule
